// ===== src/fes_consts.vh
// Opcodes, register bit positions and timing constants of the flash command sequencer
`ifndef FES_CONSTS_VH
`define FES_CONSTS_VH
`define FES_OP_BE32 8'h52
`define FES_OP_BE64 8'hd8
`define FES_OP_BE32_4B 8'h5c
`define FES_OP_BE64_4B 8'hdc
`define FES_OP_CE_A 8'hc7
`define FES_OP_CE_B 8'h60
`define FES_OP_SET_WRITE_LATCH_CMD 8'h06
`define FES_OP_CLEAR_WRITE_LATCH_CMD 8'h04
`define FES_OP_STATUS_READ_CMD 8'h05
`define FES_OP_STATUS_WRITE_CMD 8'h01
`define FES_OP_FUNCTION_REG_READ_CMD 8'h48
`define FES_OP_FUNCTION_REG_WRITE_CMD 8'h42
`define FES_OP_QEN 8'h35
`define FES_OP_QEX 8'hf5
`define FES_OP_SUS_A 8'h75
`define FES_OP_SUS_B 8'hb0
`define FES_OP_SUS_C 8'h85
`define FES_OP_RSM_A 8'h7a
`define FES_OP_RSM_B 8'h30
`define FES_OP_RSM_C 8'h8a
`define FES_SR_WIP 0
`define FES_SR_WEL 1
`define FES_SR_BP_LO 2
`define FES_SR_QE 6
`define FES_SR_STATUS_WRITE_GUARD 7
`define FES_SR_RST 8'h00
`define FES_FR_RSTEN 0
`define FES_FR_PROGRAM_SUSPENDED_FLAG 2
`define FES_FR_ERASE_SUSPENDED_FLAG 3
`define FES_FR_IRL_LO 4
`define FES_FR_RST 8'hf0
`define FES_CLK_MHZ 100
`define FES_SUS_US 100
`define FES_SUS_CYC (`FES_SUS_US * `FES_CLK_MHZ)
`define FES_BUSY_CYC 2000
`define FES_STATUS_WRITE_CMD_CYC 16
`endif

// ===== src/fes_sync.v
// Three-stage pin synchroniser with agreement on the last two stages
`timescale 1ns/1ns
`default_nettype none
module fes_sync
#(
  parameter [0:0] RST_VAL = 1'b0
)
(
  input wire clk_in,
  input wire sys_rst_in,
  input wire pin_in,
  output reg level_out
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      // Reset to the pin's idle level so no false edge follows reset
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      level_out <= RST_VAL;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Only a settled value is passed on
      if (s2_q == s3_q)
        level_out <= s3_q;
    end
  end
endmodule
`default_nettype wire

// ===== src/fes_top.v
// Flash command sequencer: erase, write latch, registers, quad mode, suspend
//
// Functional notes
// - 52h/D8h block erase, address width follows mode; the mode is held at three-byte here, so three bytes
// - 5Ch/DCh always take four address bytes
// - Erase starts only at chip-select rise
// - Latch clears when block erase finishes
// - C7h/60h full erase, latch needed, clears after
// - 06h sets write enable latch
// - Latch cleared after power-up
// - Writes need latch; volatile parameters exempt
// - Latch clears when any write completes
// - 04h clears write enable latch; here only in idle, it is ignored while suspended
// - 05h status read accepted while busy
// - 01h writes protect, guard and quad bits
// - 48h returns function register; here not answered while the suspend settles (ST_SETL)
// - 42h writes reset enable and lock bits
// - 35h enters four-bit command protocol
// - F5h returns to one-bit protocol
// - Suspend 75h/B0h/85h, resume 7Ah/30h/8Ah
// - Function bit2 program, bit3 erase suspended
// - Ready within 100us of suspend
// - Erase suspended accepts program, read, resume
// - Erase suspend sets flag, clears latch
// - Busy bit high until erase finishes
// - Four-bit cycles send high nibble first
`timescale 1ns/1ns
`default_nettype none
`include "fes_consts.vh"
module fes_top
#(
  parameter BUSY_CYC = `FES_BUSY_CYC,
  parameter SUS_CYC = `FES_SUS_CYC
)
(
  input wire clk_in,
  input wire sys_rst_in,
  input wire cs_n_in,
  input wire sclk_in,
  input wire [3:0] io_in,
  input wire program_start_in,
  output reg [3:0] io_out,
  output reg [3:0] io_oe_out,
  output reg write_enable_latch_out,
  output reg write_in_progress_out,
  output reg four_bit_command_protocol_out,
  output reg four_byte_address_mode_out,
  output reg [7:0] status_reg_out,
  output reg [7:0] function_reg_out,
  output reg erase_start_out,
  output reg [1:0] erase_kind_out,
  output reg [31:0] erase_addr_out,
  output reg erase_done_out
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_BUSY = 4'b0010;
  localparam ST_SUSP = 4'b0100;
  localparam ST_SETL = 4'b1000;
  localparam K_B32 = 2'd0;
  localparam K_B64 = 2'd1;
  localparam K_CHIP = 2'd2;
  localparam K_PROG = 2'd3;

  wire cs_n_s;
  wire sclk_s;
  wire [3:0] io_s;
  fes_sync #(.RST_VAL(1'b1)) u_cs (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(cs_n_in),
    .level_out(cs_n_s));
  fes_sync u_ck (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(sclk_in),
    .level_out(sclk_s));
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_io
      fes_sync u_io (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(io_in[g]),
        .level_out(io_s[g]));
    end
  endgenerate

  function is_sus;
    input [7:0] op;
    begin
      is_sus = (op == `FES_OP_SUS_A) || (op == `FES_OP_SUS_B) || (op == `FES_OP_SUS_C);
    end
  endfunction
  function is_rsm;
    input [7:0] op;
    begin
      is_rsm = (op == `FES_OP_RSM_A) || (op == `FES_OP_RSM_B) || (op == `FES_OP_RSM_C);
    end
  endfunction
  function [2:0] addr_bytes;
    input [7:0] op;
    input ext;
    begin
      if (op == `FES_OP_BE32_4B || op == `FES_OP_BE64_4B)
        addr_bytes = 3'd4;
      else if (op == `FES_OP_BE32 || op == `FES_OP_BE64)
        addr_bytes = ext ? 3'd4 : 3'd3;
      else if (op == `FES_OP_STATUS_WRITE_CMD || op == `FES_OP_FUNCTION_REG_WRITE_CMD)
        addr_bytes = 3'd1;
      else
        addr_bytes = 3'd0;
    end
  endfunction

  reg sclk_d1_q;
  reg cs_n_d1_q;
  reg [7:0] shift_q;
  reg [3:0] bitcnt_q;
  reg [7:0] op_q;
  reg op_valid_q;
  reg [2:0] bytecnt_q;
  reg [31:0] addr_q;
  reg [7:0] data_q;
  reg [7:0] tx_q;
  reg tx_on_q;
  reg [3:0] state_q;
  reg [31:0] cnt_q;
  reg [1:0] kind_q;
  reg wel_q;
  reg [3:0] bp_q;
  reg qe_q;
  reg status_write_guard_q;
  reg [3:0] irl_q;
  reg rsten_q;
  reg program_suspended_flag_q;
  reg erase_suspended_flag_q;
  reg quad_q;
  reg [1:0] nest_kind_q;
  reg [31:0] erase_rem_q, prog_rem_q;

  wire rise = sclk_s & ~sclk_d1_q;
  wire fall = ~sclk_s & sclk_d1_q;
  wire cs_rise = cs_n_s & ~cs_n_d1_q;
  wire cs_fall = ~cs_n_s & cs_n_d1_q;
  // One nibble per edge in quad mode, high nibble first
  wire [7:0] shift_d = quad_q ? {shift_q[3:0], io_s} : {shift_q[6:0], io_s[0]};
  wire [3:0] step = quad_q ? 4'd4 : 4'd1;
  wire byte_done = rise && (bitcnt_q + step == 4'd8);
  wire [2:0] need = addr_bytes(op_q, four_byte_address_mode_out);
  wire frame_full = op_valid_q && (bytecnt_q == need);
  wire busy = (state_q == ST_BUSY) || (state_q == ST_SETL);
  wire [7:0] sr_now = {status_write_guard_q, qe_q, bp_q, wel_q, busy};
  wire [7:0] fr_now = {irl_q, erase_suspended_flag_q, program_suspended_flag_q, 1'b0, rsten_q};

  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      sclk_d1_q <= 1'b0;
      cs_n_d1_q <= 1'b1;
      shift_q <= 8'h00;
      bitcnt_q <= 4'h0;
      op_q <= 8'h00;
      op_valid_q <= 1'b0;
      bytecnt_q <= 3'd0;
      addr_q <= 32'h00000000;
      data_q <= 8'h00;
      tx_q <= 8'h00;
      tx_on_q <= 1'b0;
      state_q <= ST_IDLE;
      cnt_q <= 32'h00000000;
      kind_q <= K_B32;
      nest_kind_q <= K_B32;
      wel_q <= 1'b0;
      bp_q <= 4'h0;
      qe_q <= 1'b0;
      status_write_guard_q <= 1'b0;
      irl_q <= 4'hf;
      rsten_q <= 1'b0;
      program_suspended_flag_q <= 1'b0;
      erase_suspended_flag_q <= 1'b0;
      quad_q <= 1'b0;
      io_out <= 4'h0;
      io_oe_out <= 4'h0;
      erase_kind_out <= K_B32;
      erase_addr_out <= 32'h00000000;
      erase_start_out <= 1'b0;
      erase_done_out <= 1'b0;
    end
    else
    begin
      sclk_d1_q <= sclk_s;
      cs_n_d1_q <= cs_n_s;
      erase_start_out <= 1'b0;
      erase_done_out <= 1'b0;
      // Internal operation timer
      if (state_q == ST_BUSY || state_q == ST_SETL)
      begin
        if (cnt_q == 32'd0)
        begin
          if (state_q == ST_SETL)
            state_q <= erase_suspended_flag_q || program_suspended_flag_q ? ST_SUSP : ST_IDLE;
          else
          begin
            state_q <= (erase_suspended_flag_q && kind_q == K_PROG) ? ST_SUSP : ST_IDLE;
            if (erase_suspended_flag_q && kind_q == K_PROG)
              kind_q <= nest_kind_q;
            wel_q <= 1'b0;
            erase_done_out <= 1'b1;
          end
        end
        else
          cnt_q <= cnt_q - 32'd1;
      end
      if (program_start_in && wel_q && (state_q == ST_IDLE || (state_q == ST_SUSP && erase_suspended_flag_q
        && !program_suspended_flag_q)))
      begin
        // Program inside an erase suspend is the nested case
        nest_kind_q <= kind_q;
        kind_q <= K_PROG;
        state_q <= ST_BUSY;
        cnt_q <= BUSY_CYC;
        wel_q <= 1'b0;
      end
      if (cs_fall)
      begin
        bitcnt_q <= 4'h0;
        op_valid_q <= 1'b0;
        bytecnt_q <= 3'd0;
        tx_on_q <= 1'b0;
      end
      if (!cs_n_s && rise)
      begin
        shift_q <= shift_d;
        bitcnt_q <= byte_done ? 4'h0 : bitcnt_q + step;
        if (byte_done)
        begin
          if (!op_valid_q)
          begin
            op_q <= shift_d;
            op_valid_q <= 1'b1;
            // Status read answered even during busy
            if (shift_d == `FES_OP_STATUS_READ_CMD)
            begin
              tx_q <= sr_now;
              tx_on_q <= 1'b1;
            end
            if (shift_d == `FES_OP_FUNCTION_REG_READ_CMD && state_q != ST_SETL)
            begin
              tx_q <= fr_now;
              tx_on_q <= 1'b1;
            end
          end
          else if (bytecnt_q < need)
          begin
            bytecnt_q <= bytecnt_q + 3'd1;
            addr_q <= {addr_q[23:0], shift_d};
            data_q <= shift_d;
          end
          else if (tx_on_q)
            tx_q <= op_q == `FES_OP_STATUS_READ_CMD ? sr_now : fr_now;
        end
      end
      if (!cs_n_s && fall && tx_on_q)
      begin
        io_oe_out <= quad_q ? 4'hf : 4'h2;
        io_out <= quad_q ? (bitcnt_q[2] ? tx_q[3:0] : tx_q[7:4])
          : {2'b00, tx_q[3'd7 - bitcnt_q[2:0]], 1'b0};
      end
      if (cs_n_s)
        io_oe_out <= 4'h0;
      // Commands act only when chip select rises on a full frame
      if (cs_rise && frame_full && bitcnt_q == 4'h0)
      begin
        if (state_q == ST_IDLE || (state_q == ST_SUSP))
        begin
          case (op_q)
            `FES_OP_SET_WRITE_LATCH_CMD:
              if (state_q == ST_IDLE || !program_suspended_flag_q)
                wel_q <= 1'b1;
            `FES_OP_CLEAR_WRITE_LATCH_CMD:
              if (state_q == ST_IDLE)
                wel_q <= 1'b0;
            `FES_OP_QEN:
              if (state_q == ST_IDLE)
                quad_q <= 1'b1;
            `FES_OP_QEX:
              if (quad_q)
                quad_q <= 1'b0;
            default:
            begin
            end
          endcase
          // Erase and register writes need the latch
          if (state_q == ST_IDLE && wel_q)
          begin
            if (op_q == `FES_OP_BE32 || op_q == `FES_OP_BE32_4B || op_q == `FES_OP_BE64
              || op_q == `FES_OP_BE64_4B || op_q == `FES_OP_CE_A || op_q == `FES_OP_CE_B)
            begin
              kind_q <= (op_q == `FES_OP_CE_A || op_q == `FES_OP_CE_B) ? K_CHIP
                : (op_q == `FES_OP_BE32 || op_q == `FES_OP_BE32_4B) ? K_B32 : K_B64;
              erase_kind_out <= (op_q == `FES_OP_CE_A || op_q == `FES_OP_CE_B) ? K_CHIP
                : (op_q == `FES_OP_BE32 || op_q == `FES_OP_BE32_4B) ? K_B32 : K_B64;
              erase_addr_out <= (need == 3'd3) ? {8'h00, addr_q[23:0]} : addr_q;
              erase_start_out <= 1'b1;
              state_q <= ST_BUSY;
              cnt_q <= BUSY_CYC;
            end
            if (op_q == `FES_OP_STATUS_WRITE_CMD)
            begin
              status_write_guard_q <= data_q[`FES_SR_STATUS_WRITE_GUARD];
              qe_q <= data_q[`FES_SR_QE];
              bp_q <= data_q[`FES_SR_BP_LO+3:`FES_SR_BP_LO];
              state_q <= ST_BUSY;
              kind_q <= K_PROG;
              cnt_q <= `FES_STATUS_WRITE_CMD_CYC;
            end
            if (op_q == `FES_OP_FUNCTION_REG_WRITE_CMD)
            begin
              rsten_q <= data_q[`FES_FR_RSTEN];
              irl_q <= data_q[`FES_FR_IRL_LO+3:`FES_FR_IRL_LO];
              wel_q <= 1'b0;
            end
          end
          // Resume reloads the timer with the count left of the suspended operation
          if (state_q == ST_SUSP && is_rsm(op_q))
          begin
            if (program_suspended_flag_q)
              program_suspended_flag_q <= 1'b0;
            else
              erase_suspended_flag_q <= 1'b0;
            state_q <= ST_BUSY;
            cnt_q <= program_suspended_flag_q ? prog_rem_q : erase_rem_q;
          end
        end
        // Suspend block erases, programs and status writes (kind K_PROG); chip erase is not suspendable
        if (state_q == ST_BUSY && is_sus(op_q) && kind_q != K_CHIP)
        begin
          if (kind_q == K_PROG)
            program_suspended_flag_q <= 1'b1;
          else
            erase_suspended_flag_q <= 1'b1;
          wel_q <= 1'b0;
          prog_rem_q <= (kind_q == K_PROG) ? cnt_q : prog_rem_q;
          erase_rem_q <= (kind_q == K_PROG) ? erase_rem_q : cnt_q;
          state_q <= ST_SETL;
          cnt_q <= SUS_CYC - 1;
        end
      end
    end
  end

  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      write_enable_latch_out <= 1'b0;
      write_in_progress_out <= 1'b0;
      four_bit_command_protocol_out <= 1'b0;
      four_byte_address_mode_out <= 1'b0;
      status_reg_out <= `FES_SR_RST;
      function_reg_out <= `FES_FR_RST;
    end
    else
    begin
      write_enable_latch_out <= wel_q;
      write_in_progress_out <= busy;
      four_bit_command_protocol_out <= quad_q;
      four_byte_address_mode_out <= 1'b0;
      status_reg_out <= sr_now;
      function_reg_out <= fr_now;
    end
  end
endmodule
`default_nettype wire

// ===== bench/fes_monitor.sv
// Port checker of the flash command sequencer
`timescale 1ns/1ns
`default_nettype none
module fes_monitor
#(
  parameter BUSY_CYC = 2000
)
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic cs_n_in,
  input wire logic write_enable_latch_out,
  input wire logic write_in_progress_out,
  input wire logic four_byte_address_mode_out,
  input wire logic [7:0] status_reg_out,
  input wire logic [7:0] function_reg_out,
  input wire logic erase_start_out,
  input wire logic [1:0] erase_kind_out,
  input wire logic erase_done_out
);
  int run_q;
  // Busy run length; a suspend restarts the count since the erase pauses
  always @(posedge clk_in)
  begin
    if (sys_rst_in || !write_in_progress_out || function_reg_out[3] || function_reg_out[2])
      run_q <= 0;
    else
      run_q <= run_q + 1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_wel_rst; $fell(sys_rst_in) |-> !write_enable_latch_out; endproperty
  a_wel_rst: assert property (p_wel_rst) else $error("latch set after reset");
  property p_start_wel; erase_start_out |-> write_enable_latch_out; endproperty
  a_start_wel: assert property (p_start_wel) else $error("erase without latch");
  property p_start_cs; erase_start_out |-> cs_n_in && $past(cs_n_in, 3); endproperty
  a_start_cs: assert property (p_start_cs) else $error("erase before select rise");
  property p_start_busy; erase_start_out |=> write_in_progress_out; endproperty
  a_start_busy: assert property (p_start_busy) else $error("no busy after start");
  property p_kind; erase_start_out |-> erase_kind_out != 2'h3; endproperty
  a_kind: assert property (p_kind) else $error("bad erase kind");
  property p_done; erase_done_out |-> ##[0:2] !write_in_progress_out && !write_enable_latch_out;
  endproperty
  a_done: assert property (p_done) else $error("latch or busy left after erase");
  property p_busy_len; run_q <= BUSY_CYC + 2; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy too long");
  property p_sr; status_reg_out[1:0] == {write_enable_latch_out, write_in_progress_out};
  endproperty
  a_sr: assert property (p_sr) else $error("status bits differ from levels");
  property p_erase_suspended_flag; $rose(function_reg_out[3]) |-> ##[0:1] !write_enable_latch_out; endproperty
  a_erase_suspended_flag: assert property (p_erase_suspended_flag) else $error("latch kept on suspend");
  property p_amode; !four_byte_address_mode_out; endproperty
  a_amode: assert property (p_amode) else $error("address mode set");
endmodule
bind fes_top fes_monitor #(.BUSY_CYC(BUSY_CYC)) mon
(
  .clk_in(clk_in),
  .sys_rst_in(sys_rst_in),
  .cs_n_in(cs_n_in),
  .write_enable_latch_out(write_enable_latch_out),
  .write_in_progress_out(write_in_progress_out),
  .four_byte_address_mode_out(four_byte_address_mode_out),
  .status_reg_out(status_reg_out),
  .function_reg_out(function_reg_out),
  .erase_start_out(erase_start_out),
  .erase_kind_out(erase_kind_out),
  .erase_done_out(erase_done_out)
);
`default_nettype wire

// ===== bench/fes_host.sv
// Host controller model driving the serial and quad link
`timescale 1ns/1ns
`default_nettype none
module fes_host
(
  input wire logic clk_in,
  input wire logic [3:0] io_out_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic [3:0] io_drv_out
);
  logic quad_q = 1'b0;
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    io_drv_out = 4'h0;
  end
  task automatic half();
    repeat (8) @(negedge clk_in);
  endtask
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    int i;
    r = 8'h00;
    for (i = 0; i < (quad_q ? 2 : 8); i++)
    begin
      io_drv_out = quad_q ? (i == 0 ? b[7:4] : b[3:0]) : {3'h0, b[7 - i]};
      half();
      sclk_out = 1'b1;
      r = {r[6:0], io_out_in[1]};
      half();
      sclk_out = 1'b0;
    end
  endtask
  task automatic frame(input logic [63:0] b, input int n, output logic [7:0] r);
    int k;
    cs_n_out = 1'b0;
    for (k = n - 1; k >= 0; k--)
      xfer(b[8 * k +: 8], r);
    half();
    cs_n_out = 1'b1;
    // Released lines must not keep showing the last bit
    io_drv_out = ~io_drv_out;
    repeat (3) half();
  endtask
endmodule
`default_nettype wire

// ===== bench/flash_erase_wel_qpi_suspend_test.sv
// Self-checking bench of the flash command sequencer
`timescale 1ns/1ns
`default_nettype none
module flash_erase_wel_qpi_suspend_test;
  localparam int BUSY = 600;
  localparam int SUS = 20;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cs_n, sclk, wel, write_in_progress, quad, e_start;
  logic prog = 1'b0;
  logic [3:0] oe_all = 4'h0;
  int n_start = 0;
  logic [3:0] io_drv, io_out, io_oe;
  logic [7:0] sr, fr, rd;
  logic [1:0] kind, skind;
  logic [31:0] eaddr, saddr;
  logic [7:0] ops [6] = '{8'h52, 8'hd8, 8'h5c, 8'hdc, 8'hc7, 8'h60};
  int nabs [6] = '{3, 3, 4, 4, 0, 0};
  logic [1:0] kinds [6] = '{0, 1, 0, 1, 2, 2};
  logic [7:0] sus [3] = '{8'h75, 8'hb0, 8'h85};
  logic [7:0] rsm [3] = '{8'h7a, 8'h30, 8'h8a};
  int errors = 0;
  int num_checks = 0;
  int i;
  always #5 clk_in = ~clk_in;
  fes_top #(.BUSY_CYC(BUSY), .SUS_CYC(SUS)) uut
  (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n), .sclk_in(sclk),
    .io_in(io_drv), .program_start_in(prog), .io_out(io_out), .io_oe_out(io_oe),
    .write_enable_latch_out(wel), .write_in_progress_out(write_in_progress),
    .four_bit_command_protocol_out(quad), .four_byte_address_mode_out(),
    .status_reg_out(sr), .function_reg_out(fr), .erase_start_out(e_start),
    .erase_kind_out(kind), .erase_addr_out(eaddr), .erase_done_out()
  );
  fes_host host
  (
    .clk_in(clk_in), .io_out_in(io_out), .cs_n_out(cs_n), .sclk_out(sclk), .io_drv_out(io_drv)
  );
  always @(posedge clk_in)
  begin
    if (!sys_rst_in)
      oe_all <= oe_all | io_oe;
    if (e_start === 1'b1)
    begin
      n_start <= n_start + 1;
      skind <= kind;
      saddr <= eaddr;
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [63:0] b, input int n);
    host.frame(b, n, rd);
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 3000 && write_in_progress !== 1'b0; k++)
      @(negedge clk_in);
    if (write_in_progress !== 1'b0)
    begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic erase(input logic [7:0] op, input int nab, input logic [1:0] ke, input logic ok);
    logic [31:0] a;
    int s0;
    a = nab == 4 ? 32'h89abcdef : nab == 3 ? 32'h00abcdef : 32'h0;
    s0 = n_start;
    send(({24'h0, op, 32'h0} >> (8 * (4 - nab))) | a, nab + 1);
    chk(n_start - s0, ok);
    if (ok)
    begin
      chk(skind, ke);
      if (nab > 0)
        chk(saddr, a);
      send(16'h0500, 2);
      chk(rd[1:0], 2'h3);
      wait_idle();
      chk(wel, 0);
    end
  endtask
  initial
  begin
    repeat (8) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (6) @(negedge clk_in);
    chk(wel, 0);
    chk(fr, 8'hf0);
    erase(8'h52, 3, 0, 0);
    send(8'h06, 1);
    chk(wel, 1);
    send(8'h04, 1);
    chk(wel, 0);
    send(8'h06, 1);
    erase(8'hd8, 2, 0, 0);
    send(8'h04, 1);
    for (i = 0; i < 6; i++)
    begin
      send(8'h06, 1);
      erase(ops[i], nabs[i], kinds[i], 1);
    end
    send(8'h06, 1);
    send(16'h01bc, 2);
    wait_idle();
    chk(sr[7:2], 6'h2f);
    chk(wel, 0);
    send(8'h06, 1);
    send(16'h4251, 2);
    wait_idle();
    chk({fr[7:4], fr[0]}, 5'h0b);
    send(16'h4800, 2);
    chk(rd, 8'h51);
    chk(oe_all, 4'h2);
    chk(io_oe, 4'h0);
    for (i = 0; i < 3; i++)
    begin
      send(8'h06, 1);
      send(32'hd8000000, 4);
      send(sus[i], 1);
      repeat (SUS) @(negedge clk_in);
      chk(fr[3], 1);
      chk(wel, 0);
      chk(write_in_progress, 0);
      send(8'h06, 1);
      chk(wel, 1);
      if (i == 0)
      begin
        prog = 1'b1;
        @(negedge clk_in);
        prog = 1'b0;
        repeat (2) @(negedge clk_in);
        chk(write_in_progress, 1);
        wait_idle();
        chk(fr[3], 1);
      end
      send(rsm[i], 1);
      chk(fr[3], 0);
      chk(write_in_progress, 1);
      wait_idle();
      chk(wel, 0);
    end
    send(8'h35, 1);
    chk(quad, 1);
    host.quad_q = 1'b1;
    send(8'h06, 1);
    chk(wel, 1);
    send(8'h04, 1);
    chk(wel, 0);
    send(8'hf5, 1);
    chk(quad, 0);
    host.quad_q = 1'b0;
    end_of_test();
  end
endmodule
`default_nettype wire
